// ### rtl/bpo_cfg.svh
// Register offsets, field positions and reset values of the I/O port.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef BPO_CFG_SVH
`define BPO_CFG_SVH

// ****************************************************************
// Register offsets (3-bit register index)
// ****************************************************************
`define BPO_OFS_PIN_LEVEL  3'h0
`define BPO_OFS_LATCH      3'h1
`define BPO_OFS_DIR        3'h2
`define BPO_OFS_MEMORY_CONTROL_REG     3'h3
`define BPO_OFS_PARALLEL_PORT_CONTROL_REG     3'h4
`define BPO_OFS_PSPBUF     3'h5

// ****************************************************************
// Field positions
// ****************************************************************
`define BPO_MEMORY_CONTROL_REG_EXTERNAL_BUS_DISABLE_BIT  7
`define BPO_PARALLEL_PORT_CONTROL_REG_IBF_BIT    7
`define BPO_PARALLEL_PORT_CONTROL_REG_IBOV_BIT   5
`define BPO_PARALLEL_PORT_CONTROL_REG_MODE_BIT   4

// ****************************************************************
// Reset values
// ****************************************************************
`define BPO_RST_DIR      8'hff
`define BPO_RST_LATCH    8'h00
`define BPO_RST_EXTERNAL_BUS_DISABLE    1'h1
`define BPO_RST_PARALLEL_PORT_MODE_ENABLE  1'h0

`endif

// ### rtl/bpo_pkg.sv
// Types shared by the I/O port modules.
// Assumes nothing of its surroundings.
package bpo_pkg;

  typedef logic [7:0] bpo_byte_t;

  // Which function owns the pins, lowest priority first
  typedef enum logic [1:0] {
    BPO_OWN_GPIO = 2'b00,
    BPO_OWN_PSP  = 2'b01,
    BPO_OWN_EMI  = 2'b10
  } bpo_owner_e;

endpackage

// ### rtl/bpo_pin_if.sv
// Carrier between the port controller and its pin multiplexer.
// Assumes one controller and one multiplexer on the same clock.
interface bpo_pin_if;
  import bpo_pkg::*;

  bpo_owner_e owner;
  bpo_byte_t  latch;
  bpo_byte_t  dir;
  bpo_byte_t  emi_dout;
  logic       emi_oe;
  logic       psp_drive;
  bpo_byte_t  pin_out;
  bpo_byte_t  pin_oe;

  modport ctrl (output owner, latch, dir, emi_dout, emi_oe, psp_drive,
                input  pin_out, pin_oe);
  modport mux  (input  owner, latch, dir, emi_dout, emi_oe, psp_drive,
                output pin_out, pin_oe);
endinterface

// ### rtl/bpo_pin_mux.sv
// Combinational pin owner selection: next pin value and enable.
// Assumes the controller registers the results before the pins.
module bpo_pin_mux (
  bpo_pin_if.mux p
);
  import bpo_pkg::*;

  // ****************************************************************
  // Per-owner drive
  // ****************************************************************
  always_comb begin
    case (p.owner)
      BPO_OWN_GPIO: begin
        p.pin_out = p.latch;
        p.pin_oe  = ~p.dir;
      end
      BPO_OWN_PSP: begin
        // Host read: latch on the pins whatever the direction bits say
        p.pin_out = p.latch;
        p.pin_oe  = {8{p.psp_drive}};
      end
      BPO_OWN_EMI: begin
        p.pin_out = p.emi_dout;
        p.pin_oe  = {8{p.emi_oe}};
      end
      default: begin
        p.pin_out = 8'h00;
        p.pin_oe  = 8'h00;
      end
    endcase
  end
endmodule

// ### rtl/bpo_psp_capture.sv
// Parallel port write buffer with full and overflow flags.
// Assumes the write strobe is a one-cycle pulse gated by mode.
module bpo_psp_capture (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_wr_strobe,
  input  wire bpo_pkg::bpo_byte_t i_pin_in,
  input  wire logic              i_full_clr,
  input  wire logic              i_ovf_clr,
  output logic                   o_full,
  output logic                   o_ovf,
  output bpo_pkg::bpo_byte_t     o_data
);
  import bpo_pkg::*;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_data <= 8'h00;
    end else if (i_wr_strobe) begin
      o_data <= i_pin_in;
    end
  end

  // Set wins over clear on both flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_full <= 1'b0;
      o_ovf  <= 1'b0;
    end else begin
      if (i_wr_strobe) begin
        o_full <= 1'b1;
      end else if (i_full_clr) begin
        o_full <= 1'b0;
      end
      if (i_wr_strobe && o_full && !i_full_clr) begin
        o_ovf <= 1'b1;
      end else if (i_ovf_clr) begin
        o_ovf <= 1'b0;
      end
    end
  end
endmodule

// ### rtl/bpo_port_top.sv
// Eight-bit bidirectional port with memory-bus and parallel-port overlays.
// Assumes synchronous pin inputs and an external memory interface and
// parallel-port strobe logic outside this block.
//
// Contract
// - Direction one makes pin input, driver off
// - Direction zero drives the latch bit out
// - Latch reads return latch, not pins
// - Eight pins, each direction set independently
// - Reset makes every pin an input
// - Port functions only while bus disabled
// - Bus enabled: pins carry low address/data
// - Bus drives and samples pins ignoring direction
// - Memory bus wins over all other functions
// - Parallel mode bit turns port parallel
// - Parallel port beats port, yields to bus
// - Parallel read drives latch, ignoring direction
// - Host write data accepted ignoring direction
// - Memory bus overlay only on large variant
`include "bpo_cfg.svh"

module bpo_port_top #(
  parameter bit HAS_EMI = 1'b1
) (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire logic [2:0]         i_addr,
  input  wire bpo_pkg::bpo_byte_t i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output bpo_pkg::bpo_byte_t      o_rdata,
  input  wire bpo_pkg::bpo_byte_t i_pin_in,
  output bpo_pkg::bpo_byte_t      o_pin_out,
  output bpo_pkg::bpo_byte_t      o_pin_oe,
  input  wire bpo_pkg::bpo_byte_t i_emi_dout,
  input  wire logic               i_emi_oe,
  output bpo_pkg::bpo_byte_t      o_emi_din,
  input  wire logic               i_psp_rd_drive,
  input  wire logic               i_psp_wr,
  output logic                    o_ext_bus_active,
  output logic                    o_psp_active
);
  import bpo_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bpo_byte_t  latch_q;
  bpo_byte_t  dir_q;
  logic       external_bus_disable_q;
  logic       parallel_port_mode_enable_q;
  bpo_owner_e owner_d;
  bpo_byte_t  rdata_d;
  logic       wr_pin_level;
  logic       wr_latch;
  logic       wr_dir;
  logic       wr_memory_control_reg;
  logic       wr_parallel_port_control_reg;
  logic       rd_pspbuf;
  logic       psp_wr_strobe;
  logic       psp_full;
  logic       psp_ovf;
  bpo_byte_t  psp_data;

  bpo_pin_if u_pins ();

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic hit(input logic [2:0] addr, input logic [2:0] ofs);
    hit = (addr == ofs);
  endfunction

  assign wr_pin_level = i_wr && hit(i_addr, `BPO_OFS_PIN_LEVEL);
  assign wr_latch     = i_wr && hit(i_addr, `BPO_OFS_LATCH);
  assign wr_dir       = i_wr && hit(i_addr, `BPO_OFS_DIR);
  assign wr_memory_control_reg    = i_wr && hit(i_addr, `BPO_OFS_MEMORY_CONTROL_REG);
  assign wr_parallel_port_control_reg    = i_wr && hit(i_addr, `BPO_OFS_PARALLEL_PORT_CONTROL_REG);
  assign rd_pspbuf    = i_rd && hit(i_addr, `BPO_OFS_PSPBUF);

  // ****************************************************************
  // Output latch
  // ****************************************************************
  // Both the pin register and the latch register land in the latch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      latch_q <= `BPO_RST_LATCH;
    end else if (wr_pin_level || wr_latch) begin
      latch_q <= i_wdata;
    end
  end

  // ****************************************************************
  // Direction register
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dir_q <= `BPO_RST_DIR;
    end else if (wr_dir) begin
      dir_q <= i_wdata;
    end
  end

  // ****************************************************************
  // Memory and parallel port control bits
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      external_bus_disable_q <= `BPO_RST_EXTERNAL_BUS_DISABLE;
    end else if (wr_memory_control_reg) begin
      external_bus_disable_q <= i_wdata[`BPO_MEMORY_CONTROL_REG_EXTERNAL_BUS_DISABLE_BIT];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      parallel_port_mode_enable_q <= `BPO_RST_PARALLEL_PORT_MODE_ENABLE;
    end else if (wr_parallel_port_control_reg) begin
      parallel_port_mode_enable_q <= i_wdata[`BPO_PARALLEL_PORT_CONTROL_REG_MODE_BIT];
    end
  end

  // ****************************************************************
  // Pin owner priority
  // ****************************************************************
  always_comb begin
    if (HAS_EMI && !external_bus_disable_q) begin
      owner_d = BPO_OWN_EMI;
    end else if (parallel_port_mode_enable_q) begin
      owner_d = BPO_OWN_PSP;
    end else begin
      owner_d = BPO_OWN_GPIO;
    end
  end

  assign u_pins.owner     = owner_d;
  assign u_pins.latch     = latch_q;
  assign u_pins.dir       = dir_q;
  assign u_pins.emi_dout  = i_emi_dout;
  assign u_pins.emi_oe    = i_emi_oe;
  assign u_pins.psp_drive = i_psp_rd_drive;

  bpo_pin_mux u_mux (
    .p (u_pins.mux)
  );

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Registered so the pins never glitch while the owner changes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin_out <= 8'h00;
      o_pin_oe  <= 8'h00;
    end else begin
      o_pin_out <= u_pins.pin_out;
      o_pin_oe  <= u_pins.pin_oe;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ext_bus_active <= 1'b0;
      o_psp_active     <= 1'b0;
    end else begin
      o_ext_bus_active <= (owner_d == BPO_OWN_EMI);
      o_psp_active     <= (owner_d == BPO_OWN_PSP);
    end
  end

  // ****************************************************************
  // Memory bus data input
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_emi_din <= 8'h00;
    end else if (owner_d == BPO_OWN_EMI) begin
      o_emi_din <= i_pin_in;
    end
  end

  // ****************************************************************
  // Parallel port write capture
  // ****************************************************************
  assign psp_wr_strobe = i_psp_wr && (owner_d == BPO_OWN_PSP);

  bpo_psp_capture u_psp (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_wr_strobe (psp_wr_strobe),
    .i_pin_in    (i_pin_in),
    .i_full_clr  (rd_pspbuf),
    .i_ovf_clr   (wr_parallel_port_control_reg && !i_wdata[`BPO_PARALLEL_PORT_CONTROL_REG_IBOV_BIT]),
    .o_full      (psp_full),
    .o_ovf       (psp_ovf),
    .o_data      (psp_data)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rdata_d = 8'h00;
    case (i_addr)
      `BPO_OFS_PIN_LEVEL: rdata_d = i_pin_in;
      `BPO_OFS_LATCH:     rdata_d = latch_q;
      `BPO_OFS_DIR:       rdata_d = dir_q;
      `BPO_OFS_MEMORY_CONTROL_REG:    rdata_d[`BPO_MEMORY_CONTROL_REG_EXTERNAL_BUS_DISABLE_BIT] = external_bus_disable_q;
      `BPO_OFS_PARALLEL_PORT_CONTROL_REG: begin
        rdata_d[`BPO_PARALLEL_PORT_CONTROL_REG_IBF_BIT]  = psp_full;
        rdata_d[`BPO_PARALLEL_PORT_CONTROL_REG_IBOV_BIT] = psp_ovf;
        rdata_d[`BPO_PARALLEL_PORT_CONTROL_REG_MODE_BIT] = parallel_port_mode_enable_q;
      end
      `BPO_OFS_PSPBUF:    rdata_d = psp_data;
      default:            rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_d : 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_GPIO_INPUT_OFF: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d == BPO_OWN_GPIO) |=> (o_pin_oe == ~$past(dir_q)))
    else $error("Input pin driver not released");

  AST_GPIO_DRIVES_LATCH: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d == BPO_OWN_GPIO)
      |=> ((o_pin_out & o_pin_oe) == ($past(latch_q) & ~$past(dir_q))))
    else $error("Output pin does not carry latch bit");

  AST_LATCH_READBACK: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == `BPO_OFS_LATCH && !i_wr) |=> (o_rdata == $past(latch_q)))
    else $error("Latch read did not return latch value");

  AST_PIN_LEVEL_READ: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_rd && i_addr == `BPO_OFS_PIN_LEVEL) |=> (o_rdata == $past(i_pin_in)))
    else $error("Pin register read did not return pin levels");

  AST_PIN_LEVEL_WRITE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == `BPO_OFS_PIN_LEVEL) |=> (latch_q == $past(i_wdata)))
    else $error("Pin register write did not reach latch");

  AST_DIR_PER_BIT: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == `BPO_OFS_DIR) |=> (dir_q == $past(i_wdata)) ##1
      ((owner_d != BPO_OWN_GPIO) || (o_pin_oe == ~$past(i_wdata, 2))))
    else $error("Direction write not applied per pin");

  AST_RESET_INPUTS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> (dir_q == `BPO_RST_DIR && o_pin_oe == 8'h00))
    else $error("Pins not inputs after reset");

  AST_EMI_OWNS_PINS: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d == BPO_OWN_EMI)
      |=> (o_pin_out == $past(i_emi_dout) && o_pin_oe == {8{$past(i_emi_oe)}}))
    else $error("Memory bus does not own the pins");

  AST_EMI_SAMPLES: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d == BPO_OWN_EMI) |=> (o_emi_din == $past(i_pin_in)))
    else $error("Memory bus input not sampled");

  AST_EMI_PRIORITY: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (HAS_EMI && !external_bus_disable_q) |-> (owner_d == BPO_OWN_EMI))
    else $error("Memory bus lost priority");

  AST_PORT_ONLY_DISABLED: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d != BPO_OWN_EMI) |-> (external_bus_disable_q || !HAS_EMI))
    else $error("Port function while bus enabled");

  AST_PSP_MODE_BIT: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == `BPO_OFS_PARALLEL_PORT_CONTROL_REG)
      |=> (parallel_port_mode_enable_q == $past(i_wdata[`BPO_PARALLEL_PORT_CONTROL_REG_MODE_BIT])))
    else $error("Parallel mode bit not taken");

  AST_PSP_OVER_GPIO: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (parallel_port_mode_enable_q && (external_bus_disable_q || !HAS_EMI)) |-> (owner_d == BPO_OWN_PSP))
    else $error("Parallel port did not override port");

  AST_PSP_READ_DRIVE: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (owner_d == BPO_OWN_PSP && i_psp_rd_drive)
      |=> (o_pin_oe == 8'hff && o_pin_out == $past(latch_q)))
    else $error("Parallel read does not drive latch");

  AST_PSP_WRITE_TAKEN: assert property (
    @(posedge i_clk) disable iff (i_rst)
    psp_wr_strobe |=> (psp_full && psp_data == $past(i_pin_in)))
    else $error("Parallel write data not captured");

  AST_SMALL_NO_EMI: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !HAS_EMI |-> (owner_d != BPO_OWN_EMI && o_ext_bus_active == 1'b0))
    else $error("Memory bus present on small variant");

endmodule

// ### verif/bpo_ext_model.sv
// Board-side model of the port pins: device drive, host drive, floating lines.
// Assumes the bench says when the host drives and with what byte.
module bpo_ext_model (
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  input  wire bpo_pkg::bpo_byte_t i_pin_out,
  input  wire bpo_pkg::bpo_byte_t i_pin_oe,
  input  wire bpo_pkg::bpo_byte_t i_host_data,
  input  wire logic               i_host_en,
  output bpo_pkg::bpo_byte_t      o_pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import bpo_pkg::*;

  bpo_byte_t float_q;

  // Undriven lines change every cycle so no stale level can be relied on
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      float_q <= 8'h55;
    end else begin
      float_q <= ~float_q;
    end
  end

  // Host write data reaches only the pins whose output enable is off
  assign o_pin_level = (i_pin_oe & i_pin_out)
                     | (~i_pin_oe & (i_host_en ? i_host_data : float_q));
endmodule

// ### verif/tb.sv
// Self-checking bench for the eight-bit port, large and small variants.
// Assumes the board model resolves the pins of the large variant.
`include "bpo_cfg.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bpo_pkg::*;

  logic       clk, rst, wr, rd, emi_oe, psp_rd, psp_wr, host_en, bus_act, psp_act, s_bus;
  logic [2:0] addr;
  bpo_byte_t  wdata, rdata, pin_in, pin_out, pin_oe, emi_dout, emi_din, host_d, s_oe, v;
  int         mismatches, check_count, cycles;

  bpo_port_top #(.HAS_EMI(1'b1)) bpo_port_top_inst (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pin_in(pin_in), .o_pin_out(pin_out), .o_pin_oe(pin_oe),
    .i_emi_dout(emi_dout), .i_emi_oe(emi_oe), .o_emi_din(emi_din),
    .i_psp_rd_drive(psp_rd), .i_psp_wr(psp_wr), .o_ext_bus_active(bus_act),
    .o_psp_active(psp_act));

  bpo_port_top #(.HAS_EMI(1'b0)) bpo_port_top_small_inst (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(), .i_pin_in(pin_in), .o_pin_out(), .o_pin_oe(s_oe),
    .i_emi_dout(emi_dout), .i_emi_oe(emi_oe), .o_emi_din(),
    .i_psp_rd_drive(psp_rd), .i_psp_wr(psp_wr), .o_ext_bus_active(s_bus),
    .o_psp_active());

  bpo_ext_model bpo_ext_model_inst (
    .i_clk(clk), .i_rst(rst), .i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_host_data(host_d), .i_host_en(host_en), .o_pin_level(pin_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input bpo_byte_t seen, input bpo_byte_t exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] a, input bpo_byte_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output bpo_byte_t d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [2:0] a, input bpo_byte_t m, input bpo_byte_t exp);
    bpo_byte_t d;
    rd_reg(a, d);
    chk(d & m, exp);
  endtask

  task automatic psp_pulse();
    @(posedge clk);
    psp_wr <= 1'b1;
    @(posedge clk);
    psp_wr <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk(pin_oe, 8'h00);
    rd_chk(`BPO_OFS_DIR, 8'hff, 8'hff);
    rd_chk(`BPO_OFS_LATCH, 8'hff, 8'h00);
    rd_chk(`BPO_OFS_MEMORY_CONTROL_REG, 8'h80, 8'h80);
    rd_chk(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'hb0, 8'h00);
    wr_reg(3'h7, 8'hff);
    rd_chk(3'h7, 8'hff, 8'h00);
    rd_chk(3'h6, 8'hff, 8'h00);
  endtask

  task automatic t_gpio();
    wr_reg(`BPO_OFS_LATCH, 8'ha5);
    for (int i = 0; i < 8; i++) begin
      wr_reg(`BPO_OFS_DIR, ~(8'h01 << i));
      tick(1);
      chk(pin_oe, 8'h01 << i);
      chk(pin_out & (8'h01 << i), 8'ha5 & (8'h01 << i));
    end
    wr_reg(`BPO_OFS_DIR, 8'h00);
    tick(1);
    chk(pin_out, 8'ha5);
  endtask

  task automatic t_rmw();
    wr_reg(`BPO_OFS_LATCH, 8'h3c);
    wr_reg(`BPO_OFS_DIR, 8'hff);
    @(posedge clk);
    host_d  <= 8'h5a;
    host_en <= 1'b1;
    tick(1);
    rd_chk(`BPO_OFS_PIN_LEVEL, 8'hff, 8'h5a);
    rd_chk(`BPO_OFS_LATCH, 8'hff, 8'h3c);
    wr_reg(`BPO_OFS_PIN_LEVEL, 8'h81);
    rd_chk(`BPO_OFS_LATCH, 8'hff, 8'h81);
    rd_reg(`BPO_OFS_LATCH, v);
    wr_reg(`BPO_OFS_LATCH, v | 8'h02);
    rd_chk(`BPO_OFS_LATCH, 8'hff, 8'h83);
  endtask

  task automatic t_emi();
    wr_reg(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'h10);
    @(posedge clk);
    emi_dout <= 8'hc3;
    emi_oe   <= 1'b1;
    psp_rd   <= 1'b1;
    host_en  <= 1'b0;
    wr_reg(`BPO_OFS_MEMORY_CONTROL_REG, 8'h00);
    tick(1);
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'hc3);
    chk({7'h0, bus_act}, 8'h01);
    chk({7'h0, psp_act}, 8'h00);
    chk({7'h0, s_bus}, 8'h00);
    chk(s_oe, 8'hff);
    @(posedge clk);
    emi_oe  <= 1'b0;
    psp_rd  <= 1'b0;
    host_d  <= 8'h96;
    host_en <= 1'b1;
    tick(1);
    chk(pin_oe, 8'h00);
    tick(1);
    chk(emi_din, 8'h96);
    psp_pulse();
    wr_reg(`BPO_OFS_MEMORY_CONTROL_REG, 8'h80);
    tick(1);
    chk({7'h0, bus_act}, 8'h00);
    chk({7'h0, psp_act}, 8'h01);
    rd_chk(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'hb0, 8'h10);
  endtask

  task automatic t_psp();
    wr_reg(`BPO_OFS_LATCH, 8'he7);
    wr_reg(`BPO_OFS_DIR, 8'h00);
    tick(1);
    chk(pin_oe, 8'h00);
    @(posedge clk);
    psp_rd <= 1'b1;
    tick(1);
    chk(pin_oe, 8'hff);
    chk(pin_out, 8'he7);
    @(posedge clk);
    psp_rd <= 1'b0;
    host_d <= 8'h4b;
    psp_pulse();
    rd_chk(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'hb0, 8'h90);
    rd_chk(`BPO_OFS_PSPBUF, 8'hff, 8'h4b);
    rd_chk(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'hb0, 8'h10);
    psp_pulse();
    psp_pulse();
    rd_chk(`BPO_OFS_PARALLEL_PORT_CONTROL_REG, 8'hb0, 8'hb0);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    rst = 1'b1;
    {wr, rd, emi_oe, psp_rd, psp_wr, host_en} = 6'h00;
    {addr, wdata, emi_dout, host_d} = 27'h000_0000;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_reset();
    t_gpio();
    t_rmw();
    t_emi();
    t_psp();
    stop_test();
  end
endmodule
